// file: src/hbridge_pkg.sv
// constants, register layouts and state types of the h-bridge controller
package hbridge_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS     = 10;
  // least pwm low phase, strictly longer than the figure
  localparam int PWM_MIN_OFF_NS    = 6000;
  localparam int PWM_MIN_OFF_CYC   = PWM_MIN_OFF_NS / CLK_PERIOD_NS + 1;
  // longest mode change delay of the bridge, in microseconds
  localparam int MODE_DELAY_MAX_US = 1800;
  localparam int MODE_DELAY_CYC    = MODE_DELAY_MAX_US * 1000 / CLK_PERIOD_NS;
  // width of each half of the direction toggle used to clear a latch
  localparam int TOGGLE_NS         = 1000;
  localparam int TOGGLE_CYC        = (TOGGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 18;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PERIOD   = 8'h04;
  localparam logic [7:0] ADDR_DUTY     = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int IRQ_FAULT_A = 0;
  localparam int IRQ_FAULT_B = 1;
  localparam int IRQ_DONE    = 2;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_000C;
  localparam logic [15:0] PERIOD_RESET = 16'h1388;
  localparam logic [15:0] DUTY_RESET   = 16'h0000;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [24:0] rsvd;
    logic        standby;
    logic        clear;
    logic        run;
    logic [1:0]  en;
    logic [1:0]  dir;
  } ctrl_s;

  typedef struct packed {
    logic [23:0] rsvd;
    logic        busy;
    logic        standby;
    logic [1:0]  fault;
    logic [1:0]  en_in;
    logic [1:0]  dir;
  } status_s;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

  // index 0 is leg a, index 1 is leg b
  typedef struct packed {
    logic [1:0] dir;
    logic       pwm;
    logic [1:0] en_out;
    logic [1:0] en_oe;
  } bridge_out_s;

  typedef struct packed {
    logic [1:0] en_in;
  } bridge_in_s;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_MODE_WAIT,
    SEQ_CLR_LOW,
    SEQ_CLR_HIGH,
    SEQ_STBY
  } seq_e;

  typedef struct packed {
    logic dir;
    logic oe;
    logic fault;
  } leg_s;

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    ctrl_s       ctrl;
    logic [15:0] period;
    logic [15:0] duty;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    seq_e        seq;
    logic [17:0] cnt;
    logic [1:0]  dir_app;
    logic [1:0]  toggle;
    logic [15:0] pwm_cnt;
    logic [15:0] per_sh;
    logic [15:0] duty_sh;
    logic        pwm;
    logic [15:0] low_cnt;
  } main_s;

endpackage : hbridge_pkg

// file: src/hb_leg.sv
// one bridge leg: direction output and open-drain enable/diagnostic pin
`timescale 1ns/1ns
module hb_leg (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic dir_req,
  input  wire logic hold_low,
  input  wire logic pin_in,
  output logic      dir,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      fault,
  output logic      fault_rise
);

  hbridge_pkg::leg_s st_q;
  hbridge_pkg::leg_s st_d;

  always_comb begin
    st_d     = st_q;
    st_d.dir = dir_req;
    st_d.oe  = hold_low;
    // released pin read low means the device reports a latched fault
    st_d.fault = !pin_in && !st_q.oe;
    fault_rise = st_d.fault && !st_q.fault;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dir     = st_q.dir;
  assign pin_out = 1'b0;
  // released pin is held high by the external pull-up
  assign pin_oe  = st_q.oe;
  assign fault   = st_q.fault;

endmodule : hb_leg

// file: src/hbridge_ctrl.sv
// axi4-lite controlled host for a full-bridge motor driver with fault latch
// How it works
// - host releases enable pins to pull-up normally
// - host reads pins to locate fault
// - direction rising edge releases the latch
// - host toggles direction of leg with low pin
// - after clearing with standby set, host drives everything low
// - with pins and pwm low, toggle clears
// - pwm low phase longer than six microseconds
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module hbridge_ctrl #(
  parameter int MODE_DELAY_CYC = hbridge_pkg::MODE_DELAY_CYC
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire hbridge_pkg::axil_req_s   axi_req,
  output hbridge_pkg::axil_rsp_s        axi_rsp,
  input  wire hbridge_pkg::bridge_in_s  bridge_in,
  output hbridge_pkg::bridge_out_s      bridge_out,
  output logic                          irq
);

  localparam logic [15:0] MIN_OFF = 16'(hbridge_pkg::PWM_MIN_OFF_CYC);
  localparam logic [17:0] TOG_LD  = 18'(hbridge_pkg::TOGGLE_CYC - 1);
  localparam logic [17:0] DEL_LD  = 18'(MODE_DELAY_CYC - 1);

  hbridge_pkg::main_s   st_q;
  hbridge_pkg::main_s   st_d;
  hbridge_pkg::ctrl_s   cw;
  hbridge_pkg::status_s stat;
  logic [31:0]          wtmp;
  logic [2:0]           w1c;
  logic [2:0]           ev;
  logic                 clear_req;
  logic                 active;
  logic [15:0]          high_lim;
  logic [15:0]          duty_eff;
  logic [1:0]           dir_req;
  logic [1:0]           hold_low;
  logic [1:0]           fault;
  logic [1:0]           fault_rise;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ****************************************
  // bridge legs
  // ****************************************
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      dir_req[i]  = st_q.dir_app[i];
      hold_low[i] = !st_q.ctrl.en[i];
      unique case (st_q.seq)
        hbridge_pkg::SEQ_IDLE, hbridge_pkg::SEQ_MODE_WAIT: begin
        end
        hbridge_pkg::SEQ_CLR_LOW: begin
          if (st_q.toggle[i]) begin
            dir_req[i] = 1'b0;
          end
        end
        hbridge_pkg::SEQ_CLR_HIGH: begin
          if (st_q.toggle[i]) begin
            dir_req[i] = 1'b1;
          end
        end
        hbridge_pkg::SEQ_STBY: begin
          dir_req[i]  = 1'b0;
          hold_low[i] = 1'b1;
        end
      endcase
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_leg
    hb_leg u_leg (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .dir_req    (dir_req[g]),
      .hold_low   (hold_low[g]),
      .pin_in     (bridge_in.en_in[g]),
      .dir        (bridge_out.dir[g]),
      .pin_out    (bridge_out.en_out[g]),
      .pin_oe     (bridge_out.en_oe[g]),
      .fault      (fault[g]),
      .fault_rise (fault_rise[g])
    );
  end

  // ****************************************
  // register slave, sequencer and pwm
  // ****************************************
  assign axi_rsp.awready = !st_q.aw_have && !st_q.bvalid;
  assign axi_rsp.wready  = !st_q.w_have && !st_q.bvalid;
  assign axi_rsp.arready = !st_q.rvalid;
  assign axi_rsp.bvalid  = st_q.bvalid;
  assign axi_rsp.bresp   = st_q.bresp;
  assign axi_rsp.rvalid  = st_q.rvalid;
  assign axi_rsp.rdata   = st_q.rdata;
  assign axi_rsp.rresp   = st_q.rresp;

  always_comb begin
    st_d      = st_q;
    wtmp      = wmerge(32'h0000_0000, st_q.wdata, st_q.wstrb);
    cw        = st_q.ctrl;
    w1c       = 3'h0;
    ev        = 3'h0;
    clear_req = 1'b0;
    stat      = '0;
    stat.busy    = st_q.seq != hbridge_pkg::SEQ_IDLE;
    stat.standby = st_q.seq == hbridge_pkg::SEQ_STBY;
    stat.fault   = fault;
    stat.en_in   = bridge_in.en_in;
    stat.dir     = bridge_out.dir;

    // write path: address and data may arrive in either order
    if (axi_req.bready && st_q.bvalid) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.aw_have && st_q.w_have) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = hbridge_pkg::RESP_OKAY;
      case (st_q.awaddr)
        hbridge_pkg::ADDR_CTRL: begin
          cw = hbridge_pkg::ctrl_s'(wmerge(st_q.ctrl, st_q.wdata,
                                           st_q.wstrb));
          clear_req         = cw.clear;
          st_d.ctrl         = cw;
          st_d.ctrl.clear   = 1'b0;
          st_d.ctrl.rsvd    = '0;
        end
        hbridge_pkg::ADDR_PERIOD: begin
          wtmp        = wmerge({16'h0000, st_q.period}, st_q.wdata,
                               st_q.wstrb);
          st_d.period = wtmp[15:0];
        end
        hbridge_pkg::ADDR_DUTY: begin
          wtmp      = wmerge({16'h0000, st_q.duty}, st_q.wdata, st_q.wstrb);
          st_d.duty = wtmp[15:0];
        end
        hbridge_pkg::ADDR_STATUS: begin
        end
        hbridge_pkg::ADDR_IRQ_STAT: begin
          w1c = wtmp[2:0];
        end
        hbridge_pkg::ADDR_IRQ_MASK: begin
          wtmp          = wmerge({29'h0, st_q.irq_mask}, st_q.wdata,
                                 st_q.wstrb);
          st_d.irq_mask = wtmp[2:0];
        end
        default: begin
          st_d.bresp = hbridge_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (axi_req.awvalid && axi_rsp.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdata  = axi_req.wdata;
      st_d.wstrb  = axi_req.wstrb;
    end

    // read path
    if (axi_req.rready && st_q.rvalid) begin
      st_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = hbridge_pkg::RESP_OKAY;
      case (axi_req.araddr)
        hbridge_pkg::ADDR_CTRL:     st_d.rdata = st_q.ctrl;
        hbridge_pkg::ADDR_PERIOD:   st_d.rdata = {16'h0000, st_q.period};
        hbridge_pkg::ADDR_DUTY:     st_d.rdata = {16'h0000, st_q.duty};
        hbridge_pkg::ADDR_STATUS:   st_d.rdata = stat;
        hbridge_pkg::ADDR_IRQ_STAT: st_d.rdata = {29'h0, st_q.irq_stat};
        hbridge_pkg::ADDR_IRQ_MASK: st_d.rdata = {29'h0, st_q.irq_mask};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = hbridge_pkg::RESP_SLVERR;
        end
      endcase
    end

    // sequencer
    unique case (st_q.seq)
      hbridge_pkg::SEQ_IDLE: begin
        if (clear_req && (fault != 2'b00)) begin
          st_d.toggle = fault;
          st_d.cnt    = TOG_LD;
          st_d.seq    = hbridge_pkg::SEQ_CLR_LOW;
        end else if (st_q.ctrl.standby) begin
          st_d.seq = hbridge_pkg::SEQ_STBY;
        end else if (st_q.ctrl.dir != st_q.dir_app) begin
          st_d.dir_app = st_q.ctrl.dir;
          st_d.cnt     = DEL_LD;
          st_d.seq     = hbridge_pkg::SEQ_MODE_WAIT;
        end
      end
      hbridge_pkg::SEQ_MODE_WAIT: begin
        if (st_q.cnt == '0) begin
          st_d.seq = hbridge_pkg::SEQ_IDLE;
        end else begin
          st_d.cnt = st_q.cnt - 18'h00001;
        end
      end
      hbridge_pkg::SEQ_CLR_LOW: begin
        if (st_q.cnt == '0) begin
          st_d.cnt = TOG_LD;
          st_d.seq = hbridge_pkg::SEQ_CLR_HIGH;
        end else begin
          st_d.cnt = st_q.cnt - 18'h00001;
        end
      end
      hbridge_pkg::SEQ_CLR_HIGH: begin
        if (st_q.cnt == '0) begin
          ev[hbridge_pkg::IRQ_DONE] = 1'b1;
          st_d.toggle = 2'b00;
          // go low at once so standby is reached well inside the delay
          st_d.seq = st_q.ctrl.standby ? hbridge_pkg::SEQ_STBY :
                                         hbridge_pkg::SEQ_IDLE;
        end else begin
          st_d.cnt = st_q.cnt - 18'h00001;
        end
      end
      hbridge_pkg::SEQ_STBY: begin
        st_d.dir_app = 2'b00;
        if (!st_q.ctrl.standby) begin
          st_d.seq = hbridge_pkg::SEQ_IDLE;
        end
      end
    endcase

    // interrupts: a new event wins over a clear in the same cycle
    ev[hbridge_pkg::IRQ_FAULT_A] = fault_rise[0];
    ev[hbridge_pkg::IRQ_FAULT_B] = fault_rise[1];
    st_d.irq_stat = (st_q.irq_stat & ~w1c) | ev;
    st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);

    // pwm: period and duty reload at a period boundary, and every cycle while inactive
    high_lim = (st_q.period > MIN_OFF) ? st_q.period - MIN_OFF : 16'h0000;
    duty_eff = (st_q.duty < high_lim) ? st_q.duty : high_lim;
    active   = st_q.ctrl.run && st_q.seq == hbridge_pkg::SEQ_IDLE;
    if (!active) begin
      st_d.per_sh  = st_q.period;
      st_d.duty_sh = duty_eff;
      st_d.pwm_cnt = duty_eff;
    end else if ({1'b0, st_q.pwm_cnt} + 17'h00001 >= {1'b0, st_q.per_sh}) begin
      st_d.per_sh  = st_q.period;
      st_d.duty_sh = duty_eff;
      st_d.pwm_cnt = 16'h0000;
    end else begin
      st_d.pwm_cnt = st_q.pwm_cnt + 16'h0001;
    end
    st_d.pwm     = active && (st_d.pwm_cnt < st_d.duty_sh);
    st_d.low_cnt = st_q.pwm ? 16'h0000 :
                   (st_q.low_cnt == 16'hFFFF) ? st_q.low_cnt :
                   st_q.low_cnt + 16'h0001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q        <= '0;
      st_q.seq    <= hbridge_pkg::SEQ_IDLE;
      st_q.ctrl   <= hbridge_pkg::CTRL_RESET;
      st_q.period <= hbridge_pkg::PERIOD_RESET;
      st_q.duty   <= hbridge_pkg::DUTY_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign bridge_out.pwm = st_q.pwm;
  assign irq            = st_q.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_released: assert property (
    (st_q.seq == hbridge_pkg::SEQ_IDLE && st_q.ctrl.en[0]) [*2]
    |-> !bridge_out.en_oe[0])
    else $error("enable pin a driven in normal operation");
  a_fault_flagged: assert property (
    (!bridge_in.en_in[1] && !bridge_out.en_oe[1] && !fault[1])
    |=> st_q.irq_stat[hbridge_pkg::IRQ_FAULT_B])
    else $error("fault on leg b not flagged");
  a_toggle_low: assert property (
    (st_q.seq == hbridge_pkg::SEQ_CLR_LOW && st_q.toggle[0])
    |=> !bridge_out.dir[0])
    else $error("faulty leg direction not low");
  a_rise_edge: assert property (
    $rose(st_q.seq == hbridge_pkg::SEQ_CLR_HIGH) && st_q.toggle[1]
    |=> $rose(bridge_out.dir[1]))
    else $error("no rising edge on leg b direction");
  a_standby_low: assert property (
    (st_q.seq == hbridge_pkg::SEQ_STBY) [*2] |->
    (bridge_out.dir == 2'b00) && !bridge_out.pwm &&
    (bridge_out.en_oe == 2'b11) && (bridge_out.en_out == 2'b00))
    else $error("standby outputs not all low");
  a_clear_pwm_off: assert property (
    (st_q.seq == hbridge_pkg::SEQ_CLR_LOW ||
     st_q.seq == hbridge_pkg::SEQ_CLR_HIGH) |=> !bridge_out.pwm)
    else $error("pwm high while clearing latch");
  a_pwm_min_off: assert property (
    $rose(bridge_out.pwm) |-> st_q.low_cnt >= MIN_OFF)
    else $error("pwm low phase too short");
  a_mode_wait: assert property (
    $rose(st_q.seq == hbridge_pkg::SEQ_MODE_WAIT) |=> !bridge_out.pwm [*8])
    else $error("pwm running during mode change delay");

endmodule : hbridge_ctrl

// file: verification/hb_device_model.sv
// behavioural model of the full-bridge device facing the controller
`timescale 1ns/1ns
module hb_device_model (
  input  wire hbridge_pkg::bridge_out_s host,
  input  wire logic [1:0]               ot,
  input  wire logic [1:0]               short_bat,
  output hbridge_pkg::bridge_in_s       pins,
  output logic [1:0]                    latched,
  output logic                          standby,
  output logic [1:0]                    hi_on,
  output logic [1:0]                    lo_on
);
  logic [1:0] en;
  logic [1:0] dir_last;
  // pulled-up wire, low when the host or a latched leg pulls it
  assign pins.en_in = ~(host.en_oe | latched);
  assign en = pins.en_in;
  // open leg has both switches off; high and low side exclusive
  assign hi_on = en & host.dir;
  assign lo_on = en & ~host.dir & {2{host.pwm}};
  assign standby = ~|latched & ~|host.dir & ~host.pwm & ~|en;
  initial begin
    latched = 2'b00;
    dir_last = 2'b00;
  end
  // a fault sets the latch, a rising direction edge clears it
  always @(ot or short_bat or lo_on or host.dir) begin
    latched = latched | ot | (short_bat & lo_on);
    latched = latched & ~(host.dir & ~dir_last & ~ot);
    dir_last = host.dir;
  end
endmodule : hb_device_model

// file: verification/h_bridge_fault_control_tb_top.sv
// self-checking testbench of the h-bridge controller
`timescale 1ns/1ns
module h_bridge_fault_control_tb_top;
  localparam int MD    = 20;
  localparam int LIMIT = 60000;
  logic                     aclk;
  logic                     aresetn;
  logic                     irq;
  logic [1:0]               ot;
  logic [1:0]               short_bat;
  logic [1:0]               latched;
  logic                     standby;
  logic [1:0]               hi_on;
  logic [1:0]               lo_on;
  logic [2:0]               mon;
  int                       error_cnt;
  int                       checks_done;
  int                       cyc;
  hbridge_pkg::axil_req_s   rq;
  hbridge_pkg::axil_rsp_s   rs;
  hbridge_pkg::bridge_out_s bo;
  hbridge_pkg::bridge_in_s  bi;

  assign mon = {bo.dir, bo.pwm};

  hbridge_ctrl #(.MODE_DELAY_CYC(MD)) dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(rq),
    .axi_rsp(rs),
    .bridge_in(bi),
    .bridge_out(bo),
    .irq(irq)
  );

  hb_device_model dev_u (
    .host(bo),
    .ot(ot),
    .short_bat(short_bat),
    .pins(bi),
    .latched(latched),
    .standby(standby),
    .hi_on(hi_on),
    .lo_on(lo_on)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw;
    logic w;
    logic done;
    @(posedge aclk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      if (rs.awready === 1'b1) aw = 1'b0;
      if (rs.wready === 1'b1) w = 1'b0;
      @(posedge aclk);
      if (!aw) rq.awvalid <= 1'b0;
      if (!w) rq.wvalid <= 1'b0;
    end
    do begin
      @(negedge aclk);
      done = (rs.bvalid === 1'b1);
      r = rs.bresp;
      @(posedge aclk);
    end while (!done);
    rq.bready <= 1'b0;
    @(negedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic done;
    @(posedge aclk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(negedge aclk);
      done = (rs.arready === 1'b1);
      @(posedge aclk);
    end while (!done);
    rq.arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      done = (rs.rvalid === 1'b1);
      d = rs.rdata;
      r = rs.rresp;
      @(posedge aclk);
    end while (!done);
    rq.rready <= 1'b0;
    @(negedge aclk);
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, hbridge_pkg::RESP_OKAY);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(r, hbridge_pkg::RESP_OKAY);
    chk(d, e);
  endtask : rdc

  // length of the next run of level v on bit b of {dir, pwm}
  task automatic run_len(input int b, input logic v, output int n);
    n = 0;
    while (mon[b] !== v) @(negedge aclk);
    while (mon[b] === v) begin
      n++;
      @(negedge aclk);
    end
  endtask : run_len

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] e [6];
    e = '{32'hC, 32'h1388, 32'h0, 32'hC, 32'h0, 32'h0};
    chk(bo, 32'h0);
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), e[i]);
    axr(8'h18, d, r);
    chk(r, hbridge_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    axw(8'h1C, 32'h1, r);
    chk(r, hbridge_pkg::RESP_SLVERR);
    wr(hbridge_pkg::ADDR_CTRL, 32'h8);
    chk(bo.en_oe, 2'b01);
    rdc(hbridge_pkg::ADDR_STATUS, 32'h8);
  endtask : t_reset

  task automatic t_modes;
    int         n;
    int         hi;
    int         lo;
    logic [1:0] d;
    wr(hbridge_pkg::ADDR_PERIOD, 32'h3E8);
    wr(hbridge_pkg::ADDR_DUTY, 32'hC8);
    for (int k = 1; k < 5; k++) begin
      d = 2'(k);
      wr(hbridge_pkg::ADDR_CTRL, {27'h0, 3'b111, d});
      rdc(hbridge_pkg::ADDR_STATUS, {24'h0, 4'h8, 2'b11, d});
      chk(bo.dir, d);
      chk(hi_on, d);
      // let the mode change delay run out before the next direction
      repeat (MD) @(negedge aclk);
      rdc(hbridge_pkg::ADDR_STATUS, {24'h0, 4'h0, 2'b11, d});
    end
    run_len(0, 1'b1, n);
    run_len(0, 1'b0, lo);
    chk(lo_on, 2'b11);
    run_len(0, 1'b1, hi);
    chk(lo_on, 2'b00);
    chk(lo, 800);
    chk(hi, 200);
  endtask : t_modes

  task automatic t_ot_a;
    int n;
    wr(hbridge_pkg::ADDR_IRQ_MASK, 32'h7);
    @(posedge aclk);
    ot <= 2'b01;
    repeat (4) @(posedge aclk);
    ot <= 2'b00;
    @(negedge aclk);
    chk(bi.en_in, 2'b10);
    rdc(hbridge_pkg::ADDR_STATUS, 32'h18);
    chk(irq, 1'b1);
    wr(hbridge_pkg::ADDR_IRQ_MASK, 32'h6);
    chk(irq, 1'b0);
    wr(hbridge_pkg::ADDR_IRQ_MASK, 32'h7);
    wr(hbridge_pkg::ADDR_CTRL, 32'h3C);
    run_len(1, 1'b1, n);
    chk(n, hbridge_pkg::TOGGLE_CYC);
    chk(latched, 2'b00);
    chk(bi.en_in, 2'b11);
    rdc(hbridge_pkg::ADDR_IRQ_STAT, 32'h5);
    wr(hbridge_pkg::ADDR_IRQ_STAT, 32'h5);
    rdc(hbridge_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
  endtask : t_ot_a

  task automatic t_sat_b;
    @(posedge aclk);
    short_bat <= 2'b10;
    while (latched[1] !== 1'b1) @(negedge aclk);
    wr(hbridge_pkg::ADDR_CTRL, 32'h7C);
    while (standby !== 1'b1) @(negedge aclk);
    chk(bo, 32'h03);
    chk(latched, 2'b00);
    rdc(hbridge_pkg::ADDR_IRQ_STAT, 32'h6);
    wr(hbridge_pkg::ADDR_IRQ_STAT, 32'h7);
    chk(irq, 1'b0);
    @(posedge aclk);
    short_bat <= 2'b00;
    wr(hbridge_pkg::ADDR_CTRL, 32'h1C);
    // leaving standby takes one more edge before the pins are released
    @(negedge aclk);
    chk(bo.en_oe, 2'b00);
  endtask : t_sat_b

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    rq = '0;
    ot = 2'b00;
    short_bat = 2'b00;
    aresetn = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset();
    t_modes();
    t_ot_a();
    t_sat_b();
    finish_test();
  end
endmodule : h_bridge_fault_control_tb_top
